// *** src/lhmb_map.vh ***
// register indices, field positions and reset values of the host mailbox
`ifndef LHMB_MAP_VH
`define LHMB_MAP_VH
`define LHMB_IDX_C4_HI 6'h00
`define LHMB_IDX_C4_LO 6'h01
`define LHMB_IDX_C3_HI 6'h02
`define LHMB_IDX_C3_LO 6'h03
`define LHMB_IDX_CTRL 6'h04
`define LHMB_IDX_ARB 6'h05
`define LHMB_IDX_IDR0 6'h08
`define LHMB_IDX_ODR0 6'h0C
`define LHMB_IDX_STR0 6'h10
`define LHMB_IDX_TWR0 6'h20
`define LHMB_BIT_C4_EN 0
`define LHMB_BIT_TWR_EN 0
`define LHMB_BIT_CD 3
`define LHMB_BIT_IBF 1
`define LHMB_BIT_OBF 0
`define LHMB_BIT_ARB_HOK 0
`define LHMB_BIT_ARB_SOK 1
`define LHMB_BIT_ARB_REL 4
`define LHMB_RST_BYTE 8'h00
`define LHMB_RST_ADDR 16'h0000
`define LHMB_OWN_NONE 2'h0
`define LHMB_OWN_HOST 2'h1
`define LHMB_OWN_SLAVE 2'h2
`endif

// *** src/lhmb_mailbox.v ***
// host mailbox: channel 4 decode, data/status registers and shared registers
`timescale 1ns/1ps
`include "lhmb_map.vh"
// Summary of operation
// [R1] software keeps channel 4 address unchanged while chan4_enable is set
// [R2] 16-bit channel 4 address, reset zero, bit 2 excluded from match
// [R3] channel 4 write goes to input_data4; read returns output_data4 or status4
// [R4] software keeps channel 4 address distinct from other channels
// [R5] input data registers are 8 bits, host write only, slave read only
// [R6] host write stores byte and latches address bit 2 as cmd_data_flag
// [R7] input data registers reset to zero
// [R8] output data registers 8 bits, slave read/write, host read only
// [R9] output data registers reset to zero
// [R10] sixteen 8-bit shared registers, read/write from both sides
// [R11] shared register 0 has separate host-written and slave-written bytes
// [R12] shared register 0 writes arbitrated, validity shown in status flags
// [R13] host right: host reads own byte, slave writes discarded
// [R14] slave right: host writes to shared register 0 discarded
// [R15] shared registers store host writes, return on reads, reset zero
// [R16] shared match uses channel 3 address, bit 4 inverted, bits 3..0 select
// [R17] input_full_flag set by host write, cleared by slave read
// [R18] output_full_flag set by slave write, cleared by host read or zero write
// [R19] cmd_data_flag sits at status bit 3, read only to slave
// [R20] channel 4 decoded only while chan4_enable is one
// [R21] slave right: slave read of host byte returns slave byte
module lhmb_mailbox (
  input wire mclk,
  input wire rst,
  input wire lclk,
  input wire [15:0] host_addr,
  input wire [7:0] host_wdata,
  input wire host_wr,
  input wire host_rd,
  output reg [7:0] host_rdata_ff,
  output reg host_ack_ff,
  input wire [5:0] slv_addr,
  input wire [7:0] slv_wdata,
  input wire slv_wr,
  input wire slv_rd,
  output reg [7:0] slv_rdata_ff
);
  // host pins pass two flip-flops
  reg [26:0] h_s1_ff;
  reg [26:0] h_s2_ff;
  reg lclk_d_ff;
  reg [15:0] c4_addr_ff;
  reg [15:0] c3_addr_ff;
  reg c4_en_ff;
  reg [7:0] idr_ff [0:3];
  reg [7:0] odr_ff [0:3];
  reg [7:0] str_ff [0:3];
  reg [7:0] twr_ff [0:15];
  reg [7:0] tw0_slv_ff;
  reg [1:0] own_ff;
  reg hok_ff;
  reg sok_ff;
  integer i;
  integer j;

  // address compare with a don't-care mask
  function match;
    input [15:0] a;
    input [15:0] ref_addr;
    input [15:0] care;
    begin
      match = ((a ^ ref_addr) & care) == 16'h0000;
    end
  endfunction

  wire [15:0] ha = h_s2_ff[15:0];
  wire [7:0] hd = h_s2_ff[23:16];
  wire lclk_s = h_s2_ff[26];
  wire lrise = lclk_s & ~lclk_d_ff;
  wire h_wr = lrise & h_s2_ff[24];
  wire h_rd = lrise & h_s2_ff[25];
  wire c4_hit = c4_en_ff & match(ha, c4_addr_ff, 16'hFFFB); // see [R2] see [R20]
  wire tw_hit = c3_addr_ff[`LHMB_BIT_TWR_EN] &
    match(ha, c3_addr_ff ^ 16'h0010, 16'hFFF0); // see [R16]
  wire [3:0] tw_sel = ha[3:0];
  wire h_tw0_wr = h_wr & tw_hit & (tw_sel == 4'h0);
  wire s_tw0_wr = slv_wr & (slv_addr == `LHMB_IDX_TWR0);
  // host loses to a slave that already owns, wins a same-cycle race
  wire h_tw0_ok = own_ff != `LHMB_OWN_SLAVE; // see [R14]
  wire s_tw0_ok = (own_ff != `LHMB_OWN_HOST) & ~(h_tw0_wr & h_tw0_ok); // see [R13]
  wire arb_rel = slv_wr & (slv_addr == `LHMB_IDX_ARB) & slv_wdata[`LHMB_BIT_ARB_REL];
  wire s_str = slv_wr & (slv_addr[5:2] == 4'h4);
  wire s_odr = slv_wr & (slv_addr[5:2] == 4'h3);
  wire s_idr_rd = slv_rd & (slv_addr[5:2] == 4'h2);

  // synchroniser and link clock edge finder
  always @(posedge mclk) begin
    if (rst) begin
      h_s1_ff <= 27'h0000000;
      h_s2_ff <= 27'h0000000;
      lclk_d_ff <= 1'b0;
    end else begin
      h_s1_ff <= {lclk, host_rd, host_wr, host_wdata, host_addr};
      h_s2_ff <= h_s1_ff;
      lclk_d_ff <= lclk_s;
    end
  end

  // slave-side configuration registers
  always @(posedge mclk) begin
    if (rst) begin
      c4_addr_ff <= `LHMB_RST_ADDR; // see [R2]
      c3_addr_ff <= `LHMB_RST_ADDR;
      c4_en_ff <= 1'b0;
    end else if (slv_wr) begin
      case (slv_addr)
        `LHMB_IDX_C4_HI: c4_addr_ff[15:8] <= slv_wdata;
        `LHMB_IDX_C4_LO: c4_addr_ff[7:0] <= slv_wdata;
        `LHMB_IDX_C3_HI: c3_addr_ff[15:8] <= slv_wdata;
        `LHMB_IDX_C3_LO: c3_addr_ff[7:0] <= slv_wdata;
        `LHMB_IDX_CTRL: c4_en_ff <= slv_wdata[`LHMB_BIT_C4_EN];
        default: c4_en_ff <= c4_en_ff;
      endcase
    end
  end

  // channel data, status and flags; hardware set wins over clear
  always @(posedge mclk) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        idr_ff[i] <= `LHMB_RST_BYTE; // see [R7]
        odr_ff[i] <= `LHMB_RST_BYTE; // see [R9]
        str_ff[i] <= `LHMB_RST_BYTE;
      end
    end else begin
      if (s_idr_rd)
        str_ff[slv_addr[1:0]][`LHMB_BIT_IBF] <= 1'b0; // see [R17]
      if (s_odr) begin
        odr_ff[slv_addr[1:0]] <= slv_wdata; // see [R8]
        str_ff[slv_addr[1:0]][`LHMB_BIT_OBF] <= 1'b1; // see [R18]
      end
      if (s_str) begin
        str_ff[slv_addr[1:0]][7:4] <= slv_wdata[7:4]; // see [R19]
        str_ff[slv_addr[1:0]][2] <= slv_wdata[2];
        if (!slv_wdata[`LHMB_BIT_OBF])
          str_ff[slv_addr[1:0]][`LHMB_BIT_OBF] <= 1'b0; // see [R18]
      end
      if (h_rd & c4_hit & ~ha[2] & ~(s_odr & slv_addr[1:0] == 2'h3))
        str_ff[3][`LHMB_BIT_OBF] <= 1'b0; // see [R18]
      if (h_wr & c4_hit) begin
        idr_ff[3] <= hd; // see [R3] see [R5]
        str_ff[3][`LHMB_BIT_CD] <= ha[2]; // see [R6]
        str_ff[3][`LHMB_BIT_IBF] <= 1'b1; // see [R17]
      end
    end
  end

  // shared registers and access-right arbitration of register 0
  always @(posedge mclk) begin
    if (rst) begin
      for (j = 0; j < 16; j = j + 1)
        twr_ff[j] <= `LHMB_RST_BYTE; // see [R15]
      tw0_slv_ff <= `LHMB_RST_BYTE;
      own_ff <= `LHMB_OWN_NONE;
      hok_ff <= 1'b0;
      sok_ff <= 1'b0;
    end else begin
      if (arb_rel)
        own_ff <= `LHMB_OWN_NONE;
      if (slv_wr & (slv_addr[5:4] == 2'h2) & (slv_addr[3:0] != 4'h0))
        twr_ff[slv_addr[3:0]] <= slv_wdata; // see [R10]
      if (s_tw0_wr) begin
        sok_ff <= s_tw0_ok; // see [R12]
        if (s_tw0_ok) begin
          tw0_slv_ff <= slv_wdata; // see [R11]
          own_ff <= `LHMB_OWN_SLAVE;
        end
      end
      if (h_wr & tw_hit) begin
        if (tw_sel != 4'h0)
          twr_ff[tw_sel] <= hd; // see [R15]
        else begin
          hok_ff <= h_tw0_ok; // see [R12]
          if (h_tw0_ok) begin
            twr_ff[0] <= hd; // see [R11] see [R14]
            own_ff <= `LHMB_OWN_HOST;
          end
        end
      end
    end
  end

  // host read answers, one pulse per matched read
  always @(posedge mclk) begin
    if (rst) begin
      host_rdata_ff <= `LHMB_RST_BYTE;
      host_ack_ff <= 1'b0;
    end else begin
      host_ack_ff <= h_rd & (c4_hit | tw_hit);
      if (h_rd & c4_hit)
        host_rdata_ff <= ha[2] ? str_ff[3] : odr_ff[3]; // see [R3] see [R8]
      else if (h_rd & tw_hit) begin
        if (tw_sel != 4'h0)
          host_rdata_ff <= twr_ff[tw_sel]; // see [R15]
        else if (own_ff == `LHMB_OWN_HOST)
          host_rdata_ff <= twr_ff[0]; // see [R13]
        else
          host_rdata_ff <= tw0_slv_ff; // see [R11]
      end
    end
  end

  // slave reads, data one cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      slv_rdata_ff <= `LHMB_RST_BYTE;
    end else if (slv_rd) begin
      case (slv_addr[5:2])
        4'h0: slv_rdata_ff <= slv_addr[1] ?
          (slv_addr[0] ? c3_addr_ff[7:0] : c3_addr_ff[15:8]) :
          (slv_addr[0] ? c4_addr_ff[7:0] : c4_addr_ff[15:8]);
        4'h1: slv_rdata_ff <= (slv_addr == `LHMB_IDX_CTRL) ? {7'h00, c4_en_ff} :
          (slv_addr == `LHMB_IDX_ARB) ? {4'h0, own_ff, sok_ff, hok_ff} : 8'h00;
        4'h2: slv_rdata_ff <= idr_ff[slv_addr[1:0]]; // see [R5]
        4'h3: slv_rdata_ff <= odr_ff[slv_addr[1:0]];
        4'h4: slv_rdata_ff <= str_ff[slv_addr[1:0]]; // see [R19]
        4'h8, 4'h9, 4'hA, 4'hB: begin
          if (slv_addr[3:0] != 4'h0)
            slv_rdata_ff <= twr_ff[slv_addr[3:0]];
          else if (own_ff == `LHMB_OWN_SLAVE)
            slv_rdata_ff <= tw0_slv_ff; // see [R21]
          else
            slv_rdata_ff <= twr_ff[0]; // see [R11]
        end
        default: slv_rdata_ff <= 8'h00;
      endcase
    end
  end
endmodule // lhmb_mailbox

// *** bench/lhmb_mailbox_asserts.sv ***
// port checks for the host mailbox
`timescale 1ns/1ps
module lhmb_mailbox_chk (
  input logic mclk,
  input logic rst,
  input logic host_wr,
  input logic host_rd,
  input logic [7:0] host_rdata_ff,
  input logic host_ack_ff,
  input logic [5:0] slv_addr,
  input logic [7:0] slv_wdata,
  input logic slv_wr,
  input logic slv_rd,
  input logic [7:0] slv_rdata_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // host side answer shape
  AST_ACK_ONE: assert property (host_ack_ff |=> !host_ack_ff) else $error("ack");
  AST_ACK_CAUSE: assert property (host_ack_ff |-> $past(host_rd) && !$past(host_wr))
    else $error("ack cause");
  AST_RST_ZERO: assert property ($fell(rst) |-> !host_ack_ff && slv_rdata_ff == 8'h00
    && host_rdata_ff == 8'h00) else $error("reset");
  AST_HRD_HOLD: assert property (!host_ack_ff |-> $stable(host_rdata_ff))
    else $error("host data");
  // slave side read data
  AST_SRD_HOLD: assert property (!$past(slv_rd) |-> $stable(slv_rdata_ff))
    else $error("slave data");
  AST_ODR_RW: assert property (slv_wr && slv_addr[5:2] == 4'h3 ##1 slv_rd && $stable(slv_addr)
    |=> slv_rdata_ff == $past(slv_wdata, 2)) else $error("odr");
  AST_TWR_RW: assert property (slv_wr && slv_addr[5:4] == 2'h2 && slv_addr[3:0] != 4'h0
    ##1 slv_rd && $stable(slv_addr) |=> slv_rdata_ff == $past(slv_wdata, 2)) else $error("twr");
  AST_UNMAPPED: assert property (slv_rd && slv_addr[5:4] == 2'h3 |=> slv_rdata_ff == 8'h00)
    else $error("unmapped");
endmodule // lhmb_mailbox_chk
bind lhmb_mailbox lhmb_mailbox_chk u_chk (.mclk, .rst, .host_wr, .host_rd, .host_rdata_ff,
  .host_ack_ff, .slv_addr, .slv_wdata, .slv_wr, .slv_rd, .slv_rdata_ff);

// *** bench/lhmb_host_model.sv ***
// behavioural host issuing link I/O cycles
`timescale 1ns/1ps
module lhmb_host_model (
  input logic mclk,
  output logic lclk,
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  input logic [7:0] host_rdata_ff,
  input logic host_ack_ff
);
  // idle link, clock parked low
  initial begin
    lclk = 0;
    host_addr = 16'hFFFF;
    host_wdata = 8'hFF;
    host_wr = 0;
    host_rd = 0;
  end
  // one cycle framed by one link clock rise; answer taken while ack stands
  task io(input logic w, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    @(posedge mclk) #1 q = 8'h00;
    ok = 0;
    host_addr = a;
    host_wdata = d;
    host_wr = w;
    host_rd = !w;
    fork
      begin
        #30 lclk = 1;
        #32 lclk = 0;
      end
      repeat (14) begin
        @(posedge mclk);
        #1;
        if (host_ack_ff === 1'b1) begin
          ok = 1;
          q = host_rdata_ff;
        end
      end
    join
    host_wr = 0;
    host_rd = 0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask
endmodule // lhmb_host_model

// *** bench/lhmb_mailbox_tb_top.sv ***
// self-checking bench for the host mailbox
`timescale 1ns/1ps
module lhmb_mailbox_tb_top;
  logic mclk = 0;
  logic rst = 1;
  logic slv_wr = 0;
  logic slv_rd = 0;
  logic [5:0] slv_addr = 6'h00;
  logic [7:0] slv_wdata = 8'h00;
  logic lclk, host_wr, host_rd, host_ack_ff, ok;
  logic [15:0] host_addr;
  logic [7:0] host_wdata, host_rdata_ff, slv_rdata_ff, q;
  logic [5:0] ix [7] = '{6'h00, 6'h01, 6'h0B, 6'h0F, 6'h13, 6'h25, 6'h3F};
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // clock and cycle ceiling
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      final_report;
    end
  end
  lhmb_mailbox dut (.mclk, .rst, .lclk, .host_addr, .host_wdata, .host_wr, .host_rd,
    .host_rdata_ff, .host_ack_ff, .slv_addr, .slv_wdata, .slv_wr, .slv_rd, .slv_rdata_ff);
  lhmb_host_model host (.mclk, .lclk, .host_addr, .host_wdata, .host_wr, .host_rd,
    .host_rdata_ff, .host_ack_ff);
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      $display("Error at %0t got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask
  // slave strobes, one cycle each
  task sw(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk) #1 slv_addr = a;
    slv_wdata = d;
    slv_wr = 1;
    @(posedge mclk) #1 slv_wr = 0;
  endtask
  task sr(input logic [5:0] a, output logic [7:0] d);
    slv_addr = a;
    slv_rd = 1;
    @(posedge mclk) #1 slv_rd = 0;
    d = slv_rdata_ff;
    @(posedge mclk) #1;
  endtask
  // reset values and an unmapped index
  task t_reset;
    foreach (ix[i]) begin
      sr(ix[i], q);
      chk(q, 8'h00);
    end
  endtask
  // channel 4 decode, flags and data paths
  task t_chan4;
    sw(6'h00, 8'h12);
    sw(6'h01, 8'h30);
    host.io(1, 16'h1234, 8'h99, q, ok);
    sr(6'h0B, q);
    chk(q, 8'h00);
    sw(6'h04, 8'h01);
    host.io(1, 16'h1234, 8'hA5, q, ok);
    chk({7'h0, ok}, 8'h00);
    sr(6'h13, q);
    chk(q, 8'h0A);
    sr(6'h0B, q);
    chk(q, 8'hA5);
    host.io(1, 16'h1230, 8'h5A, q, ok);
    sr(6'h13, q);
    chk(q, 8'h02);
    host.io(1, 16'h1238, 8'h66, q, ok);
    sr(6'h0B, q);
    chk(q, 8'h5A);
    sw(6'h0F, 8'h3C);
    sr(6'h0F, q);
    chk(q, 8'h3C);
    host.io(0, 16'h1234, 8'h00, q, ok);
    chk(q, 8'h01);
    host.io(0, 16'h1230, 8'h00, q, ok);
    chk(q, 8'h3C);
    chk({7'h0, ok}, 8'h01);
    sr(6'h13, q);
    chk(q, 8'h00);
  endtask
  // shared registers and ownership of register 0
  task t_shared;
    sw(6'h02, 8'hAB);
    sw(6'h03, 8'h01);
    host.io(1, 16'hAB15, 8'h77, q, ok);
    sr(6'h25, q);
    chk(q, 8'h77);
    sw(6'h26, 8'h99);
    sr(6'h26, q);
    chk(q, 8'h99);
    host.io(0, 16'hAB16, 8'h00, q, ok);
    chk(q, 8'h99);
    host.io(1, 16'hAB10, 8'h11, q, ok);
    sw(6'h20, 8'h22);
    sr(6'h05, q);
    chk(q, 8'h05);
    host.io(0, 16'hAB10, 8'h00, q, ok);
    chk(q, 8'h11);
    sw(6'h05, 8'h10);
    sw(6'h20, 8'h33);
    host.io(1, 16'hAB10, 8'h44, q, ok);
    sr(6'h05, q);
    chk(q, 8'h0A);
    host.io(0, 16'hAB10, 8'h00, q, ok);
    chk(q, 8'h33);
    sr(6'h20, q);
    chk(q, 8'h33);
  endtask
  // mid-run reset brings the t_reset registers and the arbitration register back to zero
  task t_rerst;
    @(posedge mclk) #1 rst = 1;
    repeat (5) @(posedge mclk);
    #1 rst = 0;
    repeat (3) @(posedge mclk);
    #1;
    t_reset;
    sr(6'h05, q);
    chk(q, 8'h00);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    #1 rst = 0;
    repeat (3) @(posedge mclk);
    #1;
    t_reset;
    t_chan4;
    t_shared;
    t_rerst;
    final_report;
  end
endmodule // lhmb_mailbox_tb_top
